// ---- include/dev_alarm_params.svh ----
// Constants for the deviation alarm evaluator.
// Assumes one 200 MHz clock and a simple strobe register port.
// Functional notes
// [RULE_01] Alarm output from type, limits, hysteresis, standby; type 0 holds it off
// [RULE_02] Types 1, 4, 5 use separate upper and lower deviation limits
// [RULE_03] Type 1 alarms when value lies outside set point band
// [RULE_04] Type 2 alarms when value exceeds set point by threshold or more
// [RULE_05] Type 3 alarms when value below set point by threshold or more
// [RULE_06] Type 4 alarms when value lies inside the deviation band
// [RULE_07] Type 5 is type 1 gated through the standby sequence
// [RULE_08] Any alarm can be routed onto control output 1 or 2
// [RULE_09] Integral and derivative both zero selects proportional-only control
// [RULE_10] Proportional-only band centre is set point plus manual reset value
// [RULE_11] P, I, D stored per PID set; edited set follows display selection
// [RULE_12] Adjustment writes of P, I, D update the active PID set
// [RULE_13] Reset selects type 2 for each of three alarms
// [RULE_14] Standby suppresses alarm until value first leaves alarm condition
// [RULE_15] Asserted alarm clears only after moving back past threshold by hysteresis
`ifndef DEV_ALARM_PARAMS_SVH
`define DEV_ALARM_PARAMS_SVH

`define REG_SET_POINT      6'h00
`define REG_ALM_TYPE       6'h01
`define REG_RUN_START      6'h02
`define REG_OUT_ASSIGN     6'h03
`define REG_MANUAL_RESET   6'h04
`define REG_PID_DISP_SEL   6'h05
`define REG_PID_ACTIVE_SEL 6'h06
`define REG_ADJ_PROP       6'h07
`define REG_ADJ_INTEG      6'h08
`define REG_ADJ_DERIV      6'h09
`define REG_PIDSET_PROP    6'h0a
`define REG_PIDSET_INTEG   6'h0b
`define REG_PIDSET_DERIV   6'h0c
`define REG_CTRL_STATUS    6'h0d
`define REG_IRQ_STATUS     6'h0e
`define REG_IRQ_MASK       6'h0f
`define REG_ALM_BASE       6'h10
`define ALM_STRIDE         6'h04
`define ALM_OFS_UPPER      2'h0
`define ALM_OFS_LOWER      2'h1
`define ALM_OFS_HYST       2'h2

`define ALM_TYPE_RESET     4'h2
`define OUT_ASSIGN_RESET   4'h0

`endif

// ---- include/dev_alarm_pkg.sv ----
// Types shared by the deviation alarm evaluator.
// Assumes the params header supplies the register map and reset constants; the alarm type codes 0 to 5 are defined here.
package dev_alarm_pkg;

  typedef enum logic [3:0] {
    ALM_OFF        = 4'h0,
    ALM_OUT_BAND   = 4'h1,
    ALM_UPPER      = 4'h2,
    ALM_LOWER      = 4'h3,
    ALM_IN_BAND    = 4'h4,
    ALM_OUT_STBY   = 4'h5
  } alarm_type_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    alarm_type_t        kind;
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic        [15:0] hyst;
  } alarm_cfg_t;

endpackage

// ---- rtl/alarm_channel.sv ----
// One alarm channel: type decode, hysteresis and standby sequence.
// Assumes signed process value and set point in one clock domain.
`timescale 1ns/1ps
`include "dev_alarm_params.svh"
module alarm_channel
(
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  input  wire dev_alarm_pkg::alarm_cfg_t cfg_i,
  input  wire logic signed [15:0]        process_value_i,
  input  wire logic signed [15:0]        set_point_i,
  input  wire logic                      standby_arm_i,
  output logic                           alarm_o
);
  import dev_alarm_pkg::*;

  typedef enum logic [1:0] {
    SB_IDLE  = 2'b00,
    SB_WAIT  = 2'b01,
    SB_LIVE  = 2'b11
  } stby_state_t;

  logic signed [17:0] dev;
  logic signed [17:0] hi;
  logic signed [17:0] lo;
  logic signed [17:0] hy;
  logic               raw_on;
  logic               raw_hold;
  logic               cond;
  logic               alarm_ff;
  logic               nxt_alarm;
  stby_state_t        sb_ff;
  stby_state_t        nxt_sb;

  assign dev = 18'(process_value_i) - 18'(set_point_i);
  assign hi  = 18'(cfg_i.upper);
  assign lo  = 18'(cfg_i.lower);
  assign hy  = 18'($signed({1'b0, cfg_i.hyst}));

  // Set and hold conditions with hysteresis
  always_comb
  begin
    raw_on   = 1'b0;
    raw_hold = 1'b0;
    case (cfg_i.kind)
      ALM_UPPER:
      begin
        raw_on   = dev >= hi;                              // [RULE_04]
        raw_hold = dev >= hi - hy;                         // [RULE_15]
      end
      ALM_LOWER:
      begin
        raw_on   = dev <= -hi;                             // [RULE_05]
        raw_hold = dev <= -hi + hy;                        // [RULE_15]
      end
      ALM_OUT_BAND, ALM_OUT_STBY:
      begin
        raw_on   = (dev > hi) || (dev < -lo);              // [RULE_02] [RULE_03]
        raw_hold = (dev > hi - hy) || (dev < -lo + hy);    // [RULE_15]
      end
      ALM_IN_BAND:
      begin
        raw_on   = (dev <= hi) && (dev >= -lo);            // [RULE_06]
        raw_hold = (dev <= hi + hy) && (dev >= -lo - hy);  // [RULE_15]
      end
      default:
      begin
        raw_on   = 1'b0;                                   // [RULE_01]
        raw_hold = 1'b0;
      end
    endcase
  end

  assign cond = alarm_ff ? raw_hold : raw_on;

  always_comb
  begin
    nxt_sb    = sb_ff;
    nxt_alarm = 1'b0;
    case (sb_ff)
      SB_IDLE: nxt_sb = SB_WAIT;
      SB_WAIT: if (!cond) nxt_sb = SB_LIVE;                // [RULE_14]
      SB_LIVE: nxt_sb = SB_LIVE;
      default: nxt_sb = SB_IDLE;
    endcase
    if (standby_arm_i)
      nxt_sb = SB_WAIT;
    if (cfg_i.kind == ALM_OUT_STBY)
      nxt_alarm = cond && (sb_ff == SB_LIVE);              // [RULE_07]
    else if (cfg_i.kind != ALM_OFF)
      nxt_alarm = cond;                                    // [RULE_01]
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sb_ff    <= SB_IDLE;
      alarm_ff <= 1'b0;
    end
    else
    begin
      sb_ff    <= nxt_sb;
      alarm_ff <= nxt_alarm;
    end
  end

  assign alarm_o = alarm_ff;

  AST_TYPE0_OFF: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_OFF) |=> !alarm_ff) else $error("Alarm on with type 0"); // [RULE_01]
  AST_STBY_GATE: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_OUT_STBY && sb_ff != SB_LIVE) |=> !alarm_ff)
    else $error("Standby alarm leaked"); // [RULE_14]
  AST_UPPER_ON: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_UPPER && dev >= hi) |=> alarm_ff)
    else $error("Upper alarm missed"); // [RULE_04]
  AST_LOWER_ON: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_LOWER && dev <= -hi) |=> alarm_ff)
    else $error("Lower alarm missed"); // [RULE_05]
  AST_HYST_HOLD: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_UPPER && alarm_ff && dev > hi - hy) |=> alarm_ff)
    else $error("Alarm dropped inside hysteresis"); // [RULE_15]
  AST_INBAND: assert property (@(posedge clock_i) disable iff (reset_i)
    (cfg_i.kind == ALM_IN_BAND && dev <= hi && dev >= -lo) |=> alarm_ff)
    else $error("In band alarm missed"); // [RULE_06]

endmodule // alarm_channel

// ---- rtl/deviation_alarm_evaluator.sv ----
// Top of the deviation alarm evaluator: registers, alarms, routing, PID sets.
// Assumes a strobe register master and synchronous measurement inputs.
`timescale 1ns/1ps
`include "dev_alarm_params.svh"
module deviation_alarm_evaluator
#(
  parameter int ALARMS = 3,
  parameter int SETS   = 8,
  parameter int SW     = 3
)
(
  input  wire logic                    clock_i,
  input  wire logic                    reset_i,
  input  wire dev_alarm_pkg::reg_req_t reg_req_i,
  output logic [31:0]                  reg_rdata_o,
  input  wire logic signed [15:0]      process_value_i,
  output logic [ALARMS-1:0]            alarm_o,
  output logic                         ctrl_out1_o,
  output logic                         ctrl_out2_o,
  output logic                         prop_only_o,
  output logic signed [15:0]           band_centre_o,
  output logic [47:0]                  active_pid_o,
  output logic                         irq_o
);
  import dev_alarm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  alarm_cfg_t         cfg_ff      [ALARMS];
  alarm_cfg_t         nxt_cfg     [ALARMS];
  logic signed [15:0] set_point_ff;
  logic signed [15:0] nxt_set_point;
  logic signed [15:0] mreset_ff;
  logic signed [15:0] nxt_mreset;
  logic [3:0]         assign_ff;
  logic [3:0]         nxt_assign;
  logic [SW-1:0]      disp_sel_ff;
  logic [SW-1:0]      nxt_disp_sel;
  logic [SW-1:0]      act_sel_ff;
  logic [SW-1:0]      nxt_act_sel;
  logic [ALARMS-1:0]  irq_stat_ff;
  logic [ALARMS-1:0]  nxt_irq_stat;
  logic [ALARMS-1:0]  irq_mask_ff;
  logic [ALARMS-1:0]  nxt_irq_mask;
  logic [ALARMS-1:0]  alarm_d_ff;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;
  logic               run_start;
  logic [ALARMS-1:0]  alarm_w;
  logic [47:0]        disp_pid;
  logic               pid_wr;
  logic [SW-1:0]      pid_wr_set;
  logic [1:0]         pid_wr_field;
  logic [5:0]         a;
  logic [15:0]        wd;

  assign a  = reg_req_i.addr;
  assign wd = reg_req_i.wdata[15:0];
  assign run_start = reg_req_i.wr && a == `REG_RUN_START && reg_req_i.wdata[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_comb
  begin
    nxt_set_point = set_point_ff;
    nxt_mreset   = mreset_ff;
    nxt_assign   = assign_ff;
    nxt_disp_sel = disp_sel_ff;
    nxt_act_sel  = act_sel_ff;
    nxt_irq_mask = irq_mask_ff;
    for (int i = 0; i < ALARMS; i++)
      nxt_cfg[i] = cfg_ff[i];
    if (reg_req_i.wr)
    begin
      case (a)
        `REG_SET_POINT:      nxt_set_point = wd;
        `REG_MANUAL_RESET:   nxt_mreset   = wd;
        `REG_OUT_ASSIGN:     nxt_assign   = wd[3:0];             // [RULE_08]
        `REG_PID_DISP_SEL:   nxt_disp_sel = wd[SW-1:0];
        `REG_PID_ACTIVE_SEL: nxt_act_sel  = wd[SW-1:0];
        `REG_IRQ_MASK:       nxt_irq_mask = wd[ALARMS-1:0];
        `REG_ALM_TYPE:
          for (int i = 0; i < ALARMS; i++)
            nxt_cfg[i].kind = alarm_type_t'(wd[4*i +: 4]);
        default:
          for (int i = 0; i < ALARMS; i++)
          begin
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_UPPER))
              nxt_cfg[i].upper = wd;                             // [RULE_02]
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_LOWER))
              nxt_cfg[i].lower = wd;                             // [RULE_02]
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_HYST))
              nxt_cfg[i].hyst  = wd;
          end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      set_point_ff <= 16'sh0;
      mreset_ff   <= 16'sh0;
      assign_ff   <= `OUT_ASSIGN_RESET;
      disp_sel_ff <= '0;
      act_sel_ff  <= '0;
      irq_mask_ff <= '0;
      for (int i = 0; i < ALARMS; i++)
        cfg_ff[i] <= '{kind: alarm_type_t'(`ALM_TYPE_RESET), upper: 16'sh0,
                       lower: 16'sh0, hyst: 16'h0};              // [RULE_13]
    end
    else
    begin
      set_point_ff <= nxt_set_point;
      mreset_ff   <= nxt_mreset;
      assign_ff   <= nxt_assign;
      disp_sel_ff <= nxt_disp_sel;
      act_sel_ff  <= nxt_act_sel;
      irq_mask_ff <= nxt_irq_mask;
      for (int i = 0; i < ALARMS; i++)
        cfg_ff[i] <= nxt_cfg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm channels

  genvar g;
  generate
    for (g = 0; g < ALARMS; g++)
    begin : g_alm
      alarm_channel u_chan
      (
        .clock_i         (clock_i),
        .reset_i         (reset_i),
        .cfg_i           (cfg_ff[g]),
        .process_value_i (process_value_i),
        .set_point_i     (set_point_ff),
        .standby_arm_i   (run_start),                            // [RULE_14]
        .alarm_o         (alarm_w[g])
      );
    end
  endgenerate

  assign alarm_o = alarm_w;

  // Route alarm n (1..3) or none (0) onto each control output
  always_comb
  begin
    ctrl_out1_o = 1'b0;
    ctrl_out2_o = 1'b0;
    for (int i = 0; i < ALARMS; i++)
    begin
      if (assign_ff[1:0] == 2'(i + 1))
        ctrl_out1_o = alarm_w[i];                                // [RULE_08]
      if (assign_ff[3:2] == 2'(i + 1))
        ctrl_out2_o = alarm_w[i];                                // [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PID sets

  always_comb
  begin
    pid_wr       = 1'b0;
    pid_wr_set   = disp_sel_ff;
    pid_wr_field = 2'h0;
    if (reg_req_i.wr)
    begin
      case (a)
        `REG_PIDSET_PROP:  begin pid_wr = 1'b1; pid_wr_field = 2'h0; end // [RULE_11]
        `REG_PIDSET_INTEG: begin pid_wr = 1'b1; pid_wr_field = 2'h1; end
        `REG_PIDSET_DERIV: begin pid_wr = 1'b1; pid_wr_field = 2'h2; end
        `REG_ADJ_PROP:
          begin pid_wr = 1'b1; pid_wr_set = act_sel_ff; pid_wr_field = 2'h0; end // [RULE_12]
        `REG_ADJ_INTEG:
          begin pid_wr = 1'b1; pid_wr_set = act_sel_ff; pid_wr_field = 2'h1; end // [RULE_12]
        `REG_ADJ_DERIV:
          begin pid_wr = 1'b1; pid_wr_set = act_sel_ff; pid_wr_field = 2'h2; end // [RULE_12]
        default: pid_wr = 1'b0;
      endcase
    end
  end

  pid_set_store #(.SETS(SETS), .SW(SW)) u_disp
  (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .wr_i       (pid_wr),
    .wr_set_i   (pid_wr_set),
    .wr_field_i (pid_wr_field),
    .wr_data_i  (wd),
    .rd_set_i   (disp_sel_ff),
    .rd_pid_o   (disp_pid)
  );

  pid_set_store #(.SETS(SETS), .SW(SW)) u_act
  (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .wr_i       (pid_wr),
    .wr_set_i   (pid_wr_set),
    .wr_field_i (pid_wr_field),
    .wr_data_i  (wd),
    .rd_set_i   (act_sel_ff),
    .rd_pid_o   (active_pid_o)
  );

  assign prop_only_o   = active_pid_o[31:16] == 16'h0 && active_pid_o[47:32] == 16'h0; // [RULE_09]
  assign band_centre_o = set_point_ff + mreset_ff;               // [RULE_10]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: rising alarm edges, write one to clear, set wins

  always_comb
  begin
    nxt_irq_stat = irq_stat_ff;
    if (reg_req_i.wr && a == `REG_IRQ_STATUS)
      nxt_irq_stat = irq_stat_ff & ~wd[ALARMS-1:0];
    nxt_irq_stat = nxt_irq_stat | (alarm_w & ~alarm_d_ff);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_stat_ff <= '0;
      alarm_d_ff  <= '0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      alarm_d_ff  <= alarm_w;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb
  begin
    nxt_rdata = 32'h0;
    if (reg_req_i.rd)
    begin
      case (a)
        `REG_SET_POINT:      nxt_rdata = 32'(unsigned'(set_point_ff));
        `REG_MANUAL_RESET:   nxt_rdata = 32'(unsigned'(mreset_ff));
        `REG_OUT_ASSIGN:     nxt_rdata = 32'(assign_ff);
        `REG_PID_DISP_SEL:   nxt_rdata = 32'(disp_sel_ff);
        `REG_PID_ACTIVE_SEL: nxt_rdata = 32'(act_sel_ff);
        `REG_PIDSET_PROP:    nxt_rdata = 32'(disp_pid[15:0]);
        `REG_PIDSET_INTEG:   nxt_rdata = 32'(disp_pid[31:16]);
        `REG_PIDSET_DERIV:   nxt_rdata = 32'(disp_pid[47:32]);
        `REG_ADJ_PROP:       nxt_rdata = 32'(active_pid_o[15:0]);
        `REG_ADJ_INTEG:      nxt_rdata = 32'(active_pid_o[31:16]);
        `REG_ADJ_DERIV:      nxt_rdata = 32'(active_pid_o[47:32]);
        `REG_CTRL_STATUS:    nxt_rdata = {26'h0, prop_only_o, ctrl_out2_o, ctrl_out1_o, alarm_w};
        `REG_IRQ_STATUS:     nxt_rdata = 32'(irq_stat_ff);
        `REG_IRQ_MASK:       nxt_rdata = 32'(irq_mask_ff);
        `REG_ALM_TYPE:
          for (int i = 0; i < ALARMS; i++)
            nxt_rdata[4*i +: 4] = cfg_ff[i].kind;
        default:
          for (int i = 0; i < ALARMS; i++)
          begin
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_UPPER))
              nxt_rdata = 32'(unsigned'(cfg_ff[i].upper));
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_LOWER))
              nxt_rdata = 32'(unsigned'(cfg_ff[i].lower));
            if (a == `REG_ALM_BASE + 6'(i) * `ALM_STRIDE + 6'(`ALM_OFS_HYST))
              nxt_rdata = 32'(cfg_ff[i].hyst);
          end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata_o = rdata_ff;

  AST_RESET_TYPE: assert property (@(posedge clock_i)
    $fell(reset_i) |-> cfg_ff[0].kind == ALM_UPPER && cfg_ff[2].kind == ALM_UPPER)
    else $error("Reset type not upper limit"); // [RULE_13]
  AST_ROUTE1: assert property (@(posedge clock_i) disable iff (reset_i)
    (assign_ff[1:0] == 2'h1) |-> ctrl_out1_o == alarm_w[0])
    else $error("Output 1 routing wrong"); // [RULE_08]
  AST_PONLY: assert property (@(posedge clock_i) disable iff (reset_i)
    (active_pid_o[47:16] != 32'h0) |-> !prop_only_o)
    else $error("Proportional only with I or D set"); // [RULE_09]
  AST_ADJ_WR: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_req_i.wr && a == `REG_ADJ_PROP && !reg_req_i.rd)
      ##1 (!(reg_req_i.wr && a != `REG_PID_ACTIVE_SEL))
      |-> active_pid_o[15:0] == $past(wd))
    else $error("Adjustment write missed active set"); // [RULE_12]

endmodule // deviation_alarm_evaluator

// ---- rtl/pid_set_store.sv ----
// Per-set storage of proportional band, integral and derivative times.
// Assumes single-cycle writes from the register block.
`timescale 1ns/1ps
module pid_set_store
#(
  parameter int SETS = 8,
  parameter int SW   = 3
)
(
  input  wire logic          clock_i,
  input  wire logic          reset_i,
  input  wire logic          wr_i,
  input  wire logic [SW-1:0] wr_set_i,
  input  wire logic [1:0]    wr_field_i,
  input  wire logic [15:0]   wr_data_i,
  input  wire logic [SW-1:0] rd_set_i,
  output logic [47:0]        rd_pid_o
);
  logic [47:0] mem_ff  [SETS];
  logic [47:0] nxt_mem [SETS];

  genvar g;
  generate
    for (g = 0; g < SETS; g++)
    begin : g_set
      always_comb
      begin
        nxt_mem[g] = mem_ff[g];
        if (wr_i && wr_set_i == SW'(g))
        begin
          case (wr_field_i)
            2'h0:    nxt_mem[g][15:0]  = wr_data_i; // [RULE_11]
            2'h1:    nxt_mem[g][31:16] = wr_data_i;
            2'h2:    nxt_mem[g][47:32] = wr_data_i;
            default: nxt_mem[g]        = mem_ff[g];
          endcase
        end
      end
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
          mem_ff[g] <= 48'h0;
        else
          mem_ff[g] <= nxt_mem[g];
      end
    end
  endgenerate

  assign rd_pid_o = mem_ff[rd_set_i];

endmodule // pid_set_store

// ---- tb/deviation_alarm_evaluator_tb.sv ----
// Self-checking bench for the deviation alarm evaluator.
// Assumes the register map and reset values of the design header.
`timescale 1ns/1ps
`include "dev_alarm_params.svh"
`define CHECK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module deviation_alarm_evaluator_tb;
  import dev_alarm_pkg::*;
  typedef struct packed {
    alarm_type_t        k;
    logic signed [15:0] v;
    logic               e;
  } case_t;
  logic                clock_i;
  logic                reset_i;
  reg_req_t            req;
  logic [31:0]         rdata;
  logic signed [15:0]  target;
  logic signed [15:0]  process_value;
  logic [2:0]          alarm;
  logic                out1;
  logic                out2;
  logic                prop_only;
  logic signed [15:0]  centre;
  logic [47:0]         pid;
  logic                irq;
  int                  mismatches;
  int                  check_count;
  case_t               cases [14];
  //////////////////////////////////////////////////////////////////////////////
  deviation_alarm_evaluator i_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .process_value_i(process_value), .alarm_o(alarm), .ctrl_out1_o(out1),
    .ctrl_out2_o(out2), .prop_only_o(prop_only), .band_centre_o(centre),
    .active_pid_o(pid), .irq_o(irq));
  sensor_model i_sensor (.clock_i(clock_i), .target_i(target),
    .process_value_o(process_value));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    `CHECK(rdata, exp)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic value_set(input logic signed [15:0] v);
    @(posedge clock_i);
    target <= v;
    idle(4);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial
  begin
    #60000;
    mismatches++;
    results();
  end
  initial
  begin
    reset_i = 1'b1;
    req = '0;
    target = -16'sd1;
    mismatches = 0;
    check_count = 0;
    cases = '{'{ALM_OUT_BAND, 16'sd11, 1'b1}, '{ALM_OUT_BAND, -16'sd6, 1'b1},
      '{ALM_OUT_BAND, 16'sd10, 1'b0}, '{ALM_OUT_BAND, -16'sd5, 1'b0},
      '{ALM_IN_BAND, -16'sd5, 1'b1}, '{ALM_IN_BAND, 16'sd10, 1'b1},
      '{ALM_IN_BAND, 16'sd11, 1'b0}, '{ALM_IN_BAND, -16'sd6, 1'b0},
      '{ALM_OFF, 16'sd11, 1'b0}, '{ALM_UPPER, 16'sd10, 1'b1},
      '{ALM_UPPER, 16'sd9, 1'b0}, '{ALM_LOWER, -16'sd10, 1'b1},
      '{ALM_LOWER, -16'sd9, 1'b0}, '{ALM_OFF, -16'sd20, 1'b0}};
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    rdchk(`REG_ALM_TYPE, 32'h0000_0222);
    `CHECK(alarm, 3'b000)
    rdchk(6'h3f, 32'h0000_0000);
    $display("test reset done");
    wr(`REG_ALM_BASE + `ALM_OFS_UPPER, 16'h000a);
    wr(`REG_ALM_BASE + `ALM_OFS_LOWER, 16'h0005);
    foreach (cases[i])
    begin
      wr(`REG_ALM_TYPE, {12'h222, cases[i].k});
      value_set(cases[i].v);
      `CHECK(alarm[0], cases[i].e)
    end
    $display("test types done");
    wr(`REG_ALM_TYPE, 16'h0222);
    wr(`REG_ALM_BASE + `ALM_OFS_HYST, 16'h0003);
    value_set(16'sd10);
    `CHECK(alarm[0], 1'b1)
    value_set(16'sd8);
    `CHECK(alarm[0], 1'b1)
    value_set(16'sd5);
    `CHECK(alarm[0], 1'b0)
    wr(`REG_ALM_BASE + `ALM_OFS_HYST, 16'h0000);
    $display("test hysteresis done");
    wr(`REG_IRQ_STATUS, 16'h0007);
    wr(`REG_IRQ_MASK, 16'h0001);
    idle(1);
    `CHECK(irq, 1'b0)
    value_set(16'sd10);
    `CHECK(irq, 1'b1)
    wr(`REG_IRQ_STATUS, 16'h0001);
    idle(1);
    `CHECK(irq, 1'b0)
    wr(`REG_IRQ_MASK, 16'h0000);
    value_set(16'sd0);
    value_set(16'sd10);
    `CHECK(irq, 1'b0)
    $display("test interrupt done");
    wr(`REG_ALM_TYPE, 16'h0322);
    wr(`REG_OUT_ASSIGN, 16'h000d);
    value_set(16'sd10);
    `CHECK({out2, out1}, 2'b01)
    value_set(-16'sd1);
    `CHECK({out2, out1}, 2'b10)
    $display("test routing done");
    value_set(16'sd11);
    wr(`REG_RUN_START, 16'h0001);
    wr(`REG_ALM_TYPE, 16'h0225);
    idle(4);
    `CHECK(alarm[0], 1'b0)
    value_set(16'sd0);
    `CHECK(alarm[0], 1'b0)
    value_set(16'sd11);
    `CHECK(alarm[0], 1'b1)
    value_set(-16'sd6);
    `CHECK(alarm[0], 1'b1)
    $display("test standby done");
    wr(`REG_PID_DISP_SEL, 16'h0002);
    wr(`REG_PIDSET_PROP, 16'h0064);
    wr(`REG_PIDSET_INTEG, 16'h00fa);
    wr(`REG_PIDSET_DERIV, 16'h002d);
    wr(`REG_PID_ACTIVE_SEL, 16'h0002);
    idle(1);
    `CHECK(pid, 48'h002d_00fa_0064)
    `CHECK(prop_only, 1'b0)
    rdchk(`REG_PIDSET_INTEG, 32'h0000_00fa);
    wr(`REG_ADJ_INTEG, 16'h0000);
    wr(`REG_ADJ_DERIV, 16'h0000);
    wr(`REG_ADJ_PROP, 16'h0050);
    idle(1);
    `CHECK(prop_only, 1'b1)
    `CHECK(pid, 48'h0000_0000_0050)
    rdchk(`REG_PIDSET_DERIV, 32'h0000_0000);
    rdchk(`REG_PIDSET_PROP, 32'h0000_0050);
    wr(`REG_PID_DISP_SEL, 16'h0001);
    rdchk(`REG_PIDSET_PROP, 32'h0000_0000);
    wr(`REG_SET_POINT, 16'h0014);
    wr(`REG_MANUAL_RESET, 16'hfffb);
    idle(1);
    `CHECK(centre, 16'sh000f)
    $display("test pid done");
    results();
  end
endmodule // deviation_alarm_evaluator_tb

// ---- tb/sensor_model.sv ----
// Measurement path model: presents the process value one clock after the bench target.
// Assumes one clock shared with the evaluator.
`timescale 1ns/1ps
module sensor_model
(
  input  wire logic               clock_i,
  input  wire logic signed [15:0] target_i,
  output logic signed [15:0]      process_value_o
);
  // Registered like a real converter output
  always_ff @(posedge clock_i)
  begin
    process_value_o <= target_i;
  end
endmodule // sensor_model
